// File: dadc_pkg.sv
// Constants, register map and state type of the dual converter control
package dadc_pkg;
  localparam int DATA_W     = 12;
  localparam int PIPE_DEPTH = 3;
  localparam int FILL_W     = 2;
  localparam int CNT_W      = 16;
  localparam int ADDR_W     = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;

  // Control register fields
  localparam int CTRL_W         = 5;
  localparam int CTRL_OE_A_N    = 0;
  localparam int CTRL_OE_B_N    = 1;
  localparam int CTRL_PDOWN     = 2;
  localparam int CTRL_FORMAT    = 3;
  localparam int CTRL_REFSEL    = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h03;

  // Status register fields
  localparam int STAT_W         = 8;
  localparam int STAT_VALID_A   = 0;
  localparam int STAT_VALID_B   = 1;
  localparam int STAT_PDOWN     = 2;
  localparam int STAT_RECOVER   = 3;
  localparam int STAT_SETTLING  = 4;
  localparam int STAT_STALL_HIT = 5;
  localparam int STAT_SLOW      = 6;
  localparam int STAT_EXT_REF   = 7;

  // Two's complement is offset binary with the sign bit inverted
  localparam logic [DATA_W-1:0] SIGN_FLIP = 12'h800;
  localparam logic [DATA_W-1:0] WORD_IDLE = 12'h000;

  // Timing
  localparam int CLK_MHZ           = 20;
  localparam int RECOVER_US        = 500;
  localparam int RECOVER_CYCLES    = RECOVER_US * CLK_MHZ;
  localparam int FMT_SETTLE_CYCLES = 4;
  localparam int STALL_CYCLES      = 64;

  typedef enum logic [1:0] {
    DADC_RUN,
    DADC_POWERED_DOWN,
    DADC_RECOVER
  } dadc_state_type;
endpackage

// File: dadc_channel.sv
// One converter channel: pipeline, output coding and three-state drive
`timescale 1ns/10ps
module dadc_channel (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // Pipeline control
  input  wire logic                       advance_in,
  input  wire logic                       flush_in,
  input  wire logic                       format_in,
  input  wire logic                       enable_n_in,
  input  wire logic [dadc_pkg::DATA_W-1:0] raw_in,
  // Output pins and state
  output logic      [dadc_pkg::DATA_W-1:0] data_out,
  output logic                            data_oe_out,
  output logic                            filled_out
);
  import dadc_pkg::*;

  logic [DATA_W-1:0] stage [PIPE_DEPTH];
  logic [FILL_W-1:0] fill;
  wire  [DATA_W-1:0] last_word = stage[PIPE_DEPTH-1];
  wire  [DATA_W-1:0] next_data = format_in ? (last_word ^ SIGN_FLIP)
                                           : last_word;
  wire               full      = (fill == FILL_W'(PIPE_DEPTH));

  // Converts on every strobe whatever the enable says
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < PIPE_DEPTH; i++) stage[i] <= WORD_IDLE;
      fill     <= '0;
      data_out <= WORD_IDLE;
    end else if (flush_in) begin
      // Samples in flight are lost across power-down
      for (int i = 0; i < PIPE_DEPTH; i++) stage[i] <= WORD_IDLE;
      fill     <= '0;
      data_out <= WORD_IDLE;
    end else if (advance_in) begin
      stage[0] <= raw_in;
      for (int i = 1; i < PIPE_DEPTH; i++) stage[i] <= stage[i-1];
      if (!full) fill <= fill + 1'b1;
      data_out <= next_data;
    end
  end

  assign data_oe_out = !enable_n_in;
  assign filled_out  = full;

  a_flush_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    flush_in |=> (data_out == WORD_IDLE) && !filled_out)
    else $error("flush left data in the pipeline");
  a_coding_msb: assert property (@(posedge clk_in) disable iff (rst_in)
    (advance_in && !flush_in) |=>
      (data_out[DATA_W-1] == ($past(last_word[DATA_W-1]) ^ $past(format_in))))
    else $error("output sign bit does not follow format");
  a_stage_flow: assert property (@(posedge clk_in) disable iff (rst_in)
    (advance_in && !flush_in) ##1 (advance_in && !flush_in)[*2] |=>
      (data_out ^ ($past(format_in) ? SIGN_FLIP : WORD_IDLE))
        == $past(raw_in, 4))
    else $error("pipeline did not deliver sample after its depth");
endmodule

// File: dadc_control.sv
// Digital control of a dual pipelined converter with an APB register port
`timescale 1ns/10ps
module dadc_control #(
  parameter int unsigned RECOVER_LIMIT = dadc_pkg::RECOVER_CYCLES
) (
  // Clock and reset
  input  wire logic                        CLK_IN,
  input  wire logic                        RST_IN,
  // APB slave
  input  wire logic                        PSEL_IN,
  input  wire logic                        PENABLE_IN,
  input  wire logic                        PWRITE_IN,
  input  wire logic [dadc_pkg::ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]                 PWDATA_IN,
  output logic      [31:0]                 PRDATA_OUT,
  output logic                             PREADY_OUT,
  output logic                             PSLVERR_OUT,
  // Converter core
  input  wire logic                        SAMPLE_STROBE_IN,
  input  wire logic [dadc_pkg::DATA_W-1:0] RAW_A_IN,
  input  wire logic [dadc_pkg::DATA_W-1:0] RAW_B_IN,
  output logic                             POWER_DOWN_OUT,
  output logic                             REFERENCE_SELECT_OUT,
  // Output pins
  output logic      [dadc_pkg::DATA_W-1:0] DATA_A_OUT,
  output logic                             DATA_A_OE_OUT,
  output logic      [dadc_pkg::DATA_W-1:0] DATA_B_OUT,
  output logic                             DATA_B_OE_OUT,
  output logic                             VALID_A_OUT,
  output logic                             VALID_B_OUT
);
  import dadc_pkg::*;

  dadc_state_type    state;
  dadc_state_type    next_state;
  logic [CTRL_W-1:0] ctrl;
  logic              format_prev;
  logic [CNT_W-1:0]  recover_cnt;
  logic [CNT_W-1:0]  settle_cnt;
  logic [CNT_W-1:0]  gap_cnt;
  logic              stall_hit;
  logic [31:0]       rdata;

  // Bus decode
  wire setup_phase = PSEL_IN && !PENABLE_IN;
  wire access      = PSEL_IN && PENABLE_IN;
  wire hit_ctrl    = (PADDR_IN == ADDR_CTRL);
  wire hit_status  = (PADDR_IN == ADDR_STATUS);
  wire mapped      = hit_ctrl || hit_status;
  wire wr_ctrl     = access && PWRITE_IN && hit_ctrl;
  wire wr_status   = access && PWRITE_IN && hit_status;

  // Control levels
  wire pd_request  = ctrl[CTRL_PDOWN];
  wire format_sel  = ctrl[CTRL_FORMAT];
  wire ref_sel     = ctrl[CTRL_REFSEL];
  wire [1:0] enable_n = {ctrl[CTRL_OE_B_N], ctrl[CTRL_OE_A_N]};

  wire [CNT_W-1:0] recover_top = CNT_W'(RECOVER_LIMIT - 1);
  wire [CNT_W-1:0] stall_top   = CNT_W'(STALL_CYCLES);
  wire [CNT_W-1:0] settle_top  = CNT_W'(FMT_SETTLE_CYCLES);
  wire powered_down = (state == DADC_POWERED_DOWN);
  wire recovering   = (state == DADC_RECOVER);
  wire clock_slow   = (gap_cnt >= stall_top);
  wire settling     = (settle_cnt != '0);
  wire format_edge  = (format_sel != format_prev);
  wire advance      = SAMPLE_STROBE_IN && !powered_down;

  // Power state sequencing
  always_comb begin
    next_state = state;
    case (state)
      DADC_RUN:
        if (pd_request) next_state = DADC_POWERED_DOWN;
      DADC_POWERED_DOWN:
        if (!pd_request) next_state = DADC_RECOVER;
      DADC_RECOVER:
        if (pd_request) next_state = DADC_POWERED_DOWN;
        else if (recover_cnt == recover_top) next_state = DADC_RUN;
      default:
        next_state = DADC_POWERED_DOWN;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) state <= DADC_RUN;
    else        state <= next_state;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN)          recover_cnt <= '0;
    else if (recovering) recover_cnt <= recover_cnt + 1'b1;
    else                 recover_cnt <= '0;
  end

  // Format change blanks the words already in flight
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      format_prev <= 1'b0;
      settle_cnt  <= '0;
    end else begin
      format_prev <= format_sel;
      if (format_edge)   settle_cnt <= settle_top;
      else if (settling) settle_cnt <= settle_cnt - 1'b1;
    end
  end

  // Strobe gap watch; stall_hit is write-one-to-clear, a new hit wins
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      gap_cnt   <= '0;
      stall_hit <= 1'b0;
    end else begin
      if (SAMPLE_STROBE_IN) gap_cnt <= '0;
      else if (!clock_slow) gap_cnt <= gap_cnt + 1'b1;
      if (clock_slow) stall_hit <= 1'b1;
      else if (wr_status && PWDATA_IN[STAT_STALL_HIT]) stall_hit <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN)       ctrl <= CTRL_RESET;
    else if (wr_ctrl) ctrl <= PWDATA_IN[CTRL_W-1:0];
  end

  // Channels
  logic [DATA_W-1:0] chan_data [2];
  logic [1:0]        chan_oe;
  logic [1:0]        chan_filled;
  logic [1:0]        chan_valid;
  wire  [DATA_W-1:0] chan_raw  [2];
  assign chan_raw[0] = RAW_A_IN;
  assign chan_raw[1] = RAW_B_IN;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    dadc_channel u_chan (
      .clk_in      (CLK_IN),
      .rst_in      (RST_IN),
      .advance_in  (advance),
      .flush_in    (powered_down),
      .format_in   (format_sel),
      .enable_n_in (enable_n[c]),
      .raw_in      (chan_raw[c]),
      .data_out    (chan_data[c]),
      .data_oe_out (chan_oe[c]),
      .filled_out  (chan_filled[c])
    );
    // Valid needs enable low and a settled, running converter
    assign chan_valid[c] = !enable_n[c] && !pd_request
                        && (state == DADC_RUN) && chan_filled[c]
                        && !settling && !clock_slow;
  end

  assign DATA_A_OUT    = chan_data[0];
  assign DATA_B_OUT    = chan_data[1];
  assign DATA_A_OE_OUT = chan_oe[0];
  assign DATA_B_OE_OUT = chan_oe[1];
  assign VALID_A_OUT   = chan_valid[0];
  assign VALID_B_OUT   = chan_valid[1];
  assign POWER_DOWN_OUT       = powered_down;
  assign REFERENCE_SELECT_OUT = ref_sel;

  // Register read mux
  wire [STAT_W-1:0] status = {ref_sel, clock_slow, stall_hit, settling,
                              recovering, powered_down, chan_valid};
  assign rdata = hit_ctrl   ? {{(32-CTRL_W){1'b0}}, ctrl} :
                 hit_status ? {{(32-STAT_W){1'b0}}, status} : 32'h0;

  // Read data captured in the setup cycle; zero-wait access
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN)           PRDATA_OUT <= 32'h0;
    else if (setup_phase) PRDATA_OUT <= rdata;
  end

  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = access && !mapped;

  // Checks
  sequence s_pd_release;
    powered_down ##1 !powered_down;
  endsequence

  sequence s_recover_hold;
    recovering && !pd_request;
  endsequence

  a_pd_holds: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (powered_down && pd_request) |=> powered_down)
    else $error("left power-down while requested");
  a_pd_enters: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (pd_request && !powered_down) |=> powered_down)
    else $error("power-down request not obeyed");
  a_recover_start: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_pd_release |-> recovering && (recover_cnt == '0))
    else $error("release did not start recovery");
  a_recover_blank: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_recover_hold |-> !VALID_A_OUT && !VALID_B_OUT)
    else $error("valid word during recovery");
  a_valid_gate: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (VALID_A_OUT |-> !ctrl[CTRL_OE_A_N] && !POWER_DOWN_OUT && DATA_A_OE_OUT))
    else $error("channel A valid while disabled");
  a_float_b: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(ctrl[CTRL_OE_B_N]) |-> !DATA_B_OE_OUT && !VALID_B_OUT)
    else $error("channel B still driven after disable");
  a_settle_blank: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    format_edge |=> (!VALID_A_OUT && !VALID_B_OUT)[*4])
    else $error("valid word right after format change");
  a_stall_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    clock_slow |-> (!VALID_A_OUT && !VALID_B_OUT) ##1 stall_hit)
    else $error("stall not flagged");
  a_convert_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (SAMPLE_STROBE_IN && !powered_down && !pd_request) |-> advance)
    else $error("conversion stopped while running");
  a_ref_follow: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    wr_ctrl |=> REFERENCE_SELECT_OUT == $past(PWDATA_IN[CTRL_REFSEL]))
    else $error("reference select not applied");
endmodule

// File: dadc_receiver.sv
// Receiving logic model: qualifies and captures the sample words
`timescale 1ns/10ps
module dadc_receiver (
  // Clock and sample tick
  input  wire logic        clk_in,
  input  wire logic        strobe_in,
  // Word pins and their qualifiers
  input  wire logic [11:0] pins_a_in,
  input  wire logic [11:0] pins_b_in,
  input  wire logic [1:0]  valid_in,
  // Captured words
  output logic      [11:0] cap_a_out,
  output logic      [11:0] cap_b_out,
  output logic      [1:0]  cap_ok_out
);
  logic took;

  always @(posedge clk_in) begin
    took <= strobe_in;
  end

  // Words move near the rising edge, so take them on the falling one
  always @(negedge clk_in) begin
    if (took) begin
      cap_a_out  <= pins_a_in;
      cap_b_out  <= pins_b_in;
      cap_ok_out <= valid_in;
    end
  end
endmodule

// File: dadc_control_tb.sv
// Self-checking bench for the dual converter control block
`timescale 1ns/10ps
module dadc_control_tb;
  import dadc_pkg::*;
  localparam int REC = 20;
  logic clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, strobe = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd, seed = 32'h2359c527;
  logic              pready, pslverr, pd, refsel, oe_a, oe_b, v_a, v_b, err;
  logic [DATA_W-1:0] raw_a = '0, raw_b = '0, d_a, d_b, cap_a, cap_b;
  logic [DATA_W-1:0] qa[$], qb[$];
  logic [1:0]        cap_ok;
  logic [4:0]        ctrl = CTRL_RESET;
  int                err_count = 0, n_compared = 0, since = 0;
  // Wire level on each three-state bus
  wire [DATA_W-1:0] pin_a = oe_a ? d_a : 'z;
  wire [DATA_W-1:0] pin_b = oe_b ? d_b : 'z;

  dadc_control #(.RECOVER_LIMIT(REC)) dut (.CLK_IN(clk_in), .RST_IN(rst_in),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SAMPLE_STROBE_IN(strobe), .RAW_A_IN(raw_a),
    .RAW_B_IN(raw_b), .POWER_DOWN_OUT(pd), .REFERENCE_SELECT_OUT(refsel),
    .DATA_A_OUT(d_a), .DATA_A_OE_OUT(oe_a), .DATA_B_OUT(d_b),
    .DATA_B_OE_OUT(oe_b), .VALID_A_OUT(v_a), .VALID_B_OUT(v_b));
  dadc_receiver rx (.clk_in(clk_in), .strobe_in(strobe), .pins_a_in(pin_a),
    .pins_b_in(pin_b), .valid_in({v_b, v_a}), .cap_a_out(cap_a),
    .cap_b_out(cap_b), .cap_ok_out(cap_ok));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk_in);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    pen <= 1;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      err_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
    // Only the power-down, format and reference-select bits restart the settle count
    if (w && a == ADDR_CTRL && wd[4:2] != ctrl[4:2]) since = 0;
    if (w && a == ADDR_CTRL) ctrl = wd[4:0];
  endtask

  // One strobe every third cycle; words judged once the pipe is fresh
  task automatic samples(input int n, input logic chk);
    logic [DATA_W-1:0] fl;
    logic [1:0]        ev;
    repeat (n) begin
      @(posedge clk_in);
      seed = xs(seed);
      strobe <= 1;
      raw_a <= seed[11:0];
      raw_b <= seed[27:16];
      qa.push_back(seed[11:0]);
      qb.push_back(seed[27:16]);
      @(posedge clk_in);
      strobe <= 0;
      @(posedge clk_in);
      #1;
      since++;
      fl = ctrl[3] ? SIGN_FLIP : WORD_IDLE;
      ev = ~ctrl[1:0] & {2{~ctrl[2]}};
      if (chk && since >= 4) begin
        check("valid", {v_b, v_a}, ev);
        check("cap_ok", cap_ok, ev);
        if (ev[0]) check("word a", cap_a, qa[$-3] ^ fl);
        if (ev[1]) check("word b", cap_b, qb[$-3] ^ fl);
      end
    end
  endtask

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  initial begin
    #(50 * 30000);
    err_count++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 0;
    #1;
    check("oe reset", {oe_b, oe_a}, 2'b00);
    apb(0, ADDR_CTRL, 0);
    check("ctrl reset", rd, CTRL_RESET);
    apb(0, 8'h3c, 0);
    check("unmapped", rd, 0);
    check("slverr", err, 1);
    $display("test reset done");
    apb(1, ADDR_CTRL, 0);
    samples(8, 1);
    check("oe on", {oe_b, oe_a}, 2'b11);
    apb(1, ADDR_CTRL, 32'h1);
    samples(4, 1);
    check("oe a off", {oe_b, oe_a}, 2'b10);
    apb(1, ADDR_CTRL, 32'h2);
    samples(4, 1);
    check("oe b off", {oe_b, oe_a}, 2'b01);
    apb(1, ADDR_CTRL, 32'h0);
    samples(4, 1);
    $display("test enables done");
    apb(1, ADDR_CTRL, 32'h18);
    samples(8, 1);
    check("ref sel", refsel, 1);
    apb(0, ADDR_STATUS, 0);
    check("ext ref", rd[STAT_EXT_REF], 1);
    $display("test format done");
    apb(1, ADDR_CTRL, 32'h1c);
    repeat (2) @(posedge clk_in);
    #1;
    check("pd", {pd, v_b, v_a, d_a}, {3'b100, WORD_IDLE});
    samples(3, 0);
    check("pd hold", pd, 1);
    apb(1, ADDR_CTRL, 32'h0);
    samples(3, 0);
    check("recover", {pd, v_b, v_a}, 0);
    repeat (REC) @(posedge clk_in);
    // Back-to-back strobes exercise the full-rate pipeline path
    repeat (6) begin
      @(posedge clk_in);
      seed = xs(seed);
      strobe <= 1;
      raw_a <= seed[11:0];
      raw_b <= seed[27:16];
      qa.push_back(seed[11:0]);
      qb.push_back(seed[27:16]);
    end
    samples(8, 1);
    $display("test power down done");
    repeat (70) @(posedge clk_in);
    #1;
    check("stall valid", {v_b, v_a}, 0);
    apb(0, ADDR_STATUS, 0);
    check("stall seen", rd[STAT_STALL_HIT], 1);
    $display("test stall done");
    summarize();
  end
endmodule
